//--- rtl/tpw_defs.vh
// Constants shared by the tire pressure window classifier
`ifndef TPW_DEFS_VH
`define TPW_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define TPW_ADDR_CTRL       8'h00
`define TPW_ADDR_LOW_THR    8'h04
`define TPW_ADDR_HIGH_THR   8'h08
`define TPW_ADDR_STATUS     8'h0C
`define TPW_ADDR_INT_STATUS 8'h10
`define TPW_ADDR_INT_ENABLE 8'h14
`define TPW_ADDR_INT_CLEAR  8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TPW_CTRL_RUN        0
`define TPW_STAT_CODE_LSB   0
`define TPW_STAT_CODE_MSB   7
`define TPW_STAT_LOW_CMP    8
`define TPW_STAT_HIGH_CMP   9
`define TPW_STAT_UNDER      10
`define TPW_STAT_CORRECT    11
`define TPW_STAT_OVER       12
`define TPW_INT_SAMPLE      0
`define TPW_INT_UNDER       1
`define TPW_INT_OVER        2
`define TPW_INT_BAD         3
`define TPW_INT_W           4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TPW_RST_RUN         1'b1
`define TPW_RST_LOW_THR     8'h5D
`define TPW_RST_HIGH_THR    8'h65
`define TPW_RST_INT_ENABLE  4'h0

// ----------------------------------------------------------------
// Gain stage and timing
// ----------------------------------------------------------------
`define TPW_PGA_GAIN        10'h004
`define TPW_CODE_MAX        8'hFF
`define TPW_CLK_PERIOD_NS   40
`define TPW_SAMPLE_PERIOD_NS 640000
`define TPW_SAMPLE_CYCLES   (`TPW_SAMPLE_PERIOD_NS / `TPW_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define TPW_RESP_OKAY       2'h0
`define TPW_RESP_SLVERR     2'h2

`endif

//--- rtl/tpw_rate_div.v
// Divider giving a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
`default_nettype none

module tpw_rate_div #(
  parameter integer DIV = 16000,
  parameter integer W = 14
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Control
  input wire enable,
  // Tick
  output reg tick
);

  reg [W-1:0] cnt_r;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= {W{1'b0}};
      tick <= 1'b0;
    end else if (!enable) begin
      cnt_r <= {W{1'b0}};
      tick <= 1'b0;
    end else if (cnt_r == DIV[W-1:0] - 1'b1) begin
      cnt_r <= {W{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule // tpw_rate_div

`default_nettype wire

//--- rtl/tpw_compare.v
// Digital comparator of a sample code against a threshold
`timescale 1ns/1ps
`default_nettype none

module tpw_compare #(
  parameter STRICT = 0
) (
  // Operands
  input wire [7:0] code,
  input wire [7:0] threshold,
  // Positive output
  output wire out_pos
);

  // STRICT=1: high above threshold; STRICT=0: low only below threshold
  assign out_pos = (STRICT != 0) ? (code > threshold) : (code >= threshold);

endmodule // tpw_compare

`default_nettype wire

//--- rtl/tpw_classifier.v
// Tire pressure window classifier with AXI4-Lite registers
//
// Functional notes
// - The sensor code passes a fixed gain of four, always active, before it becomes the sample code.
// - New samples are taken on a divided enable matching about 1.56 thousand samples per second.
// - The low-limit comparator output is low when the sample is below the low threshold, else high.
// - The low-limit comparator compares the sample code against the low threshold, reset to 93.
// - The high-limit comparator output is high when the sample exceeds the high threshold, else low.
// - The high-limit comparator compares against the high threshold, reset to 101, otherwise alike.
// - The under-pressure flag is high only when both comparator outputs are low.
// - The correct-pressure flag is high only when low comparator is high and high comparator is low.
// - The over-pressure flag is high only when both comparator outputs are high.
// - The three flags leave on three separate active-high outputs.
`timescale 1ns/1ps
`default_nettype none
`include "tpw_defs.vh"

module tpw_classifier #(
  parameter integer SAMPLE_CYCLES = `TPW_SAMPLE_CYCLES
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Conditioned sensor code
  input wire [7:0] sensor_code,
  // Pressure flags
  output reg under_pressure,
  output reg correct_pressure,
  output reg over_pressure,
  output reg sample_valid,
  // Interrupt
  output wire irq,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg run_r;
  reg [7:0] low_thr_r;
  reg [7:0] high_thr_r;
  reg [7:0] sample_r;
  reg low_cmp_r;
  reg high_cmp_r;
  reg [`TPW_INT_W-1:0] int_status_r;
  reg [`TPW_INT_W-1:0] int_status_nxt;
  reg [`TPW_INT_W-1:0] int_enable_r;
  reg [`TPW_INT_W-1:0] int_event;
  reg aw_held_r;
  reg [7:0] aw_addr_r;
  reg w_held_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg [31:0] rd_data_nxt;
  reg rd_hit_nxt;
  reg wr_hit;
  reg under_nxt;
  reg correct_nxt;
  reg over_nxt;
  reg bad_nxt;
  wire sample_tick;
  wire [9:0] amp_full;
  wire [7:0] amp_code;
  wire low_cmp;
  wire high_cmp;
  wire wr_go;
  wire [7:0] wr_byte;
  wire wr_lane0;
  wire ar_go;

  // ----------------------------------------------------------------
  // Gain stage
  // ----------------------------------------------------------------
  // Gain of four, clipped at full scale like a saturated converter
  assign amp_full = {2'b00, sensor_code} * `TPW_PGA_GAIN;
  assign amp_code = (amp_full[9:8] != 2'b00) ? `TPW_CODE_MAX : amp_full[7:0];

  // ----------------------------------------------------------------
  // Sample rate
  // ----------------------------------------------------------------
  // Restarts from zero whenever run is cleared
  tpw_rate_div #(
    .DIV(SAMPLE_CYCLES),
    .W(14)
  ) u_rate_div (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .enable(run_r),
    .tick(sample_tick)
  );

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  // Low compare inclusive, high compare strict: equal codes stay in the window
  tpw_compare #(
    .STRICT(0)
  ) u_low_limit_comparator (
    .code(amp_code),
    .threshold(low_thr_r),
    .out_pos(low_cmp)
  );

  tpw_compare #(
    .STRICT(1)
  ) u_high_limit_comparator (
    .code(amp_code),
    .threshold(high_thr_r),
    .out_pos(high_cmp)
  );

  // ----------------------------------------------------------------
  // Pressure decoders
  // ----------------------------------------------------------------
  // Crossed case needs a low threshold above the high one;
  // no flag decoder matches it, so all three flags drop
  always @* begin
    under_nxt = ~low_cmp & ~high_cmp;
    correct_nxt = low_cmp & ~high_cmp;
    over_nxt = low_cmp & high_cmp;
    bad_nxt = ~low_cmp & high_cmp;
  end

  // Flags move only on a sample tick, all three together
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sample_r <= 8'h00;
      low_cmp_r <= 1'b0;
      high_cmp_r <= 1'b0;
      under_pressure <= 1'b0;
      correct_pressure <= 1'b0;
      over_pressure <= 1'b0;
      sample_valid <= 1'b0;
    end else begin
      sample_valid <= sample_tick;
      if (sample_tick) begin
        sample_r <= amp_code;
        low_cmp_r <= low_cmp;
        high_cmp_r <= high_cmp;
        under_pressure <= under_nxt;
        correct_pressure <= correct_nxt;
        over_pressure <= over_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  // Under and over events fire on entry only
  always @* begin
    int_event = {`TPW_INT_W{1'b0}};
    int_event[`TPW_INT_SAMPLE] = sample_tick;
    int_event[`TPW_INT_UNDER] = sample_tick & under_nxt & ~under_pressure;
    int_event[`TPW_INT_OVER] = sample_tick & over_nxt & ~over_pressure;
    int_event[`TPW_INT_BAD] = sample_tick & bad_nxt;
  end

  // Set wins over a clear in the same cycle
  always @* begin
    int_status_nxt = int_status_r;
    if (wr_go && wr_lane0 && aw_addr_r == `TPW_ADDR_INT_CLEAR) begin
      int_status_nxt = int_status_r & ~wr_byte[`TPW_INT_W-1:0];
    end
    int_status_nxt = int_status_nxt | int_event;
  end

  // Level output while any enabled status bit is set
  assign irq = |(int_status_r & int_enable_r);

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data in either order; response waits for both,
  // and nothing new is taken until the response is accepted
  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
  assign wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign wr_byte = w_data_r[7:0];
  assign wr_lane0 = w_strb_r[0];

  // Read-only registers accept and drop writes; unmapped ones answer an error
  always @* begin
    case (aw_addr_r)
      `TPW_ADDR_CTRL: wr_hit = 1'b1;
      `TPW_ADDR_LOW_THR: wr_hit = 1'b1;
      `TPW_ADDR_HIGH_THR: wr_hit = 1'b1;
      `TPW_ADDR_STATUS: wr_hit = 1'b1;
      `TPW_ADDR_INT_STATUS: wr_hit = 1'b1;
      `TPW_ADDR_INT_ENABLE: wr_hit = 1'b1;
      `TPW_ADDR_INT_CLEAR: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_held_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TPW_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `TPW_RESP_OKAY : `TPW_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Only byte lane 0 carries writable register bits
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      run_r <= `TPW_RST_RUN;
      low_thr_r <= `TPW_RST_LOW_THR;
      high_thr_r <= `TPW_RST_HIGH_THR;
      int_enable_r <= `TPW_RST_INT_ENABLE;
      int_status_r <= {`TPW_INT_W{1'b0}};
    end else begin
      int_status_r <= int_status_nxt;
      if (wr_go && wr_lane0) begin
        case (aw_addr_r)
          `TPW_ADDR_CTRL: begin
            run_r <= wr_byte[`TPW_CTRL_RUN];
          end
          `TPW_ADDR_LOW_THR: begin
            low_thr_r <= wr_byte;
          end
          `TPW_ADDR_HIGH_THR: begin
            high_thr_r <= wr_byte;
          end
          `TPW_ADDR_INT_ENABLE: begin
            int_enable_r <= wr_byte[`TPW_INT_W-1:0];
          end
          default: begin
            run_r <= run_r;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  // One read at a time; unmapped addresses return zero and an error
  assign s_axi_arready = ~s_axi_rvalid;
  assign ar_go = s_axi_arvalid & s_axi_arready;

  always @* begin
    rd_data_nxt = 32'h00000000;
    rd_hit_nxt = 1'b1;
    case (s_axi_araddr)
      `TPW_ADDR_CTRL: begin
        rd_data_nxt[`TPW_CTRL_RUN] = run_r;
      end
      `TPW_ADDR_LOW_THR: begin
        rd_data_nxt[7:0] = low_thr_r;
      end
      `TPW_ADDR_HIGH_THR: begin
        rd_data_nxt[7:0] = high_thr_r;
      end
      `TPW_ADDR_STATUS: begin
        rd_data_nxt[`TPW_STAT_CODE_MSB:`TPW_STAT_CODE_LSB] = sample_r;
        rd_data_nxt[`TPW_STAT_LOW_CMP] = low_cmp_r;
        rd_data_nxt[`TPW_STAT_HIGH_CMP] = high_cmp_r;
        rd_data_nxt[`TPW_STAT_UNDER] = under_pressure;
        rd_data_nxt[`TPW_STAT_CORRECT] = correct_pressure;
        rd_data_nxt[`TPW_STAT_OVER] = over_pressure;
      end
      `TPW_ADDR_INT_STATUS: begin
        rd_data_nxt[`TPW_INT_W-1:0] = int_status_r;
      end
      `TPW_ADDR_INT_ENABLE: begin
        rd_data_nxt[`TPW_INT_W-1:0] = int_enable_r;
      end
      `TPW_ADDR_INT_CLEAR: begin
        rd_data_nxt = 32'h00000000;
      end
      default: begin
        rd_hit_nxt = 1'b0;
      end
    endcase
  end

  // Read data stand in a register until the master accepts them
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TPW_RESP_OKAY;
    end else if (ar_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data_nxt;
      s_axi_rresp <= rd_hit_nxt ? `TPW_RESP_OKAY : `TPW_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // tpw_classifier

`default_nettype wire

//--- tb/tpw_classifier_assertions.sv
// Concurrent checks on the classifier ports
`timescale 1ns/1ps
`default_nettype none
module tpw_checker #(
  parameter integer SAMPLE_CYCLES = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Flags
  input wire logic under_pressure,
  input wire logic correct_pressure,
  input wire logic over_pressure,
  input wire logic sample_valid,
  // AXI handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire [2:0] flags = {under_pressure, correct_pressure, over_pressure};
  logic [15:0] gap_r;
  logic seen_r;
  // Cycles since the last sample pulse
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gap_r <= 16'h0000;
      seen_r <= 1'b0;
    end else if (sample_valid) begin
      gap_r <= 16'h0000;
      seen_r <= 1'b1;
    end else
      gap_r <= gap_r + 16'h0001;
  end
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  flags_onehot_a: assert property ($onehot0(flags)) else $error("flags not one-hot");
  flag_update_a: assert property (!$stable(flags) |-> ##[0:1] sample_valid)
    else $error("flags moved without sample");
  sample_gap_a: assert property (sample_valid && seen_r |-> gap_r == SAMPLE_CYCLES - 1)
    else $error("sample spacing wrong");
  write_answer_a: assert property (wr_take |=> ##1 s_axi_bvalid) else $error("no write response");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  read_answer_a: assert property (rd_take |=> s_axi_rvalid) else $error("no read data");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  ar_block_a: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
endmodule // tpw_checker
bind tpw_classifier tpw_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
  .clk_sys, .reset_n, .under_pressure, .correct_pressure, .over_pressure, .sample_valid,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

//--- tb/tpw_obc_model.sv
// Onboard computer model latching the three pressure pins
`timescale 1ns/1ps
`default_nettype none
module tpw_obc_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Pressure pins
  input wire logic under_pressure,
  input wire logic correct_pressure,
  input wire logic over_pressure,
  input wire logic sample_valid,
  // Latched view
  output logic [2:0] seen_r
);
  // Reads the pins once per new sample
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      seen_r <= 3'b000;
    else if (sample_valid)
      seen_r <= {under_pressure, correct_pressure, over_pressure};
  end
endmodule // tpw_obc_model
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the pressure window classifier
`timescale 1ns/1ps
`default_nettype none
`include "tpw_defs.vh"
module tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sensor_code = 8'h00;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  wire under_pressure, correct_pressure, over_pressure, sample_valid, irq;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [2:0] seen;
  int n_fail = 0;
  int n_compared = 0;
  int n_idle = 0;
  logic [31:0] rd, ex;
  logic [1:0] rs;
  // Rows of sensor code, low and high threshold
  logic [23:0] cases [10] = '{24'h175D65, 24'h185D65, 24'h195D65, 24'h1A5D65, 24'h005D65,
    24'hFF5D65, 24'h405D65, 24'h175C64, 24'h195C64, 24'h1EC832};
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  tpw_classifier #(.SAMPLE_CYCLES(8)) u_dut (
    .clk_sys, .reset_n, .sensor_code, .under_pressure, .correct_pressure, .over_pressure,
    .sample_valid, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready
  );
  tpw_obc_model u_obc (.clk_sys, .reset_n, .under_pressure, .correct_pressure,
    .over_pressure, .sample_valid, .seen_r(seen));
  // ----------------
  // Tasks
  // ----------------
  task automatic note(input string m);
    n_fail++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk_reg(input [31:0] got, input [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) note(m);
  endtask
  task automatic chk_flags(input [2:0] exp);
    n_compared++;
    if ({under_pressure, correct_pressure, over_pressure} !== exp || seen !== exp) note("flags");
  endtask
  // Ready for the answer is offered with the request; only the watchdog ends a wait
  task automatic axi_wr(input [7:0] a, input [31:0] d, output [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_rd(input [7:0] a, output [31:0] d, output [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic wait_sv;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (sample_valid !== 1'b1 && n < 40);
    if (n >= 40) note("no sample");
  endtask
  // Second pulse is the first sample sure to have seen the new code; model settles by the falling edge
  task automatic apply(input [7:0] s);
    @(posedge clk_sys);
    sensor_code <= s;
    wait_sv();
    wait_sv();
    @(negedge clk_sys);
  endtask
  function automatic [31:0] exp_stat(input [7:0] s, input [7:0] lo, input [7:0] hi);
    logic [9:0] p;
    logic [7:0] c;
    logic l, h;
    p = {2'b00, s} << 2;
    c = (p > 10'h0FF) ? 8'hFF : p[7:0];
    l = c >= lo;
    h = c > hi;
    return {19'h0, l & h, l & !h, !l & !h, h, l, c};
  endfunction
  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------
  // Tests
  // ----------------
  initial begin
    repeat (20000) @(posedge clk_sys);
    note("timeout");
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    chk_flags(3'b000);
    axi_rd(`TPW_ADDR_CTRL, rd, rs);
    chk_reg(rd, 32'h1, "ctrl");
    axi_rd(`TPW_ADDR_LOW_THR, rd, rs);
    chk_reg(rd, 32'h5D, "low threshold");
    axi_rd(`TPW_ADDR_HIGH_THR, rd, rs);
    chk_reg(rd, 32'h65, "high threshold");
    axi_rd(`TPW_ADDR_INT_ENABLE, rd, rs);
    chk_reg(rd, 32'h0, "int enable");
    axi_rd(`TPW_ADDR_INT_CLEAR, rd, rs);
    chk_reg(rd, 32'h0, "int clear");
    axi_rd(8'h1C, rd, rs);
    chk_reg({rd[29:0], rs}, 32'h2, "unmapped read");
    axi_wr(8'h1C, 32'h0, rs);
    chk_reg({30'h0, rs}, 32'h2, "unmapped write");
    s_axi_wstrb <= 4'hE;
    axi_wr(`TPW_ADDR_LOW_THR, 32'hFF, rs);
    s_axi_wstrb <= 4'hF;
    axi_rd(`TPW_ADDR_LOW_THR, rd, rs);
    chk_reg(rd, 32'h5D, "masked write");
    $display("test reset_map done");
    foreach (cases[i]) begin
      axi_wr(`TPW_ADDR_LOW_THR, {24'h0, cases[i][15:8]}, rs);
      axi_wr(`TPW_ADDR_HIGH_THR, {24'h0, cases[i][7:0]}, rs);
      apply(cases[i][23:16]);
      ex = exp_stat(cases[i][23:16], cases[i][15:8], cases[i][7:0]);
      chk_flags({ex[10], ex[11], ex[12]});
      axi_rd(`TPW_ADDR_STATUS, rd, rs);
      chk_reg(rd, ex, "status");
    end
    $display("test classify done");
    axi_wr(`TPW_ADDR_LOW_THR, 32'h5D, rs);
    axi_wr(`TPW_ADDR_HIGH_THR, 32'h65, rs);
    axi_wr(`TPW_ADDR_INT_CLEAR, 32'hF, rs);
    axi_wr(`TPW_ADDR_INT_ENABLE, 32'h2, rs);
    apply(8'h18);
    chk_reg({31'h0, irq}, 32'h0, "irq masked");
    apply(8'h00);
    chk_reg({31'h0, irq}, 32'h1, "irq raised");
    axi_rd(`TPW_ADDR_INT_STATUS, rd, rs);
    chk_reg(rd & 32'h3, 32'h3, "int status");
    axi_wr(`TPW_ADDR_INT_ENABLE, 32'h0, rs);
    chk_reg({31'h0, irq}, 32'h0, "irq disabled");
    axi_wr(`TPW_ADDR_INT_ENABLE, 32'h2, rs);
    chk_reg({31'h0, irq}, 32'h1, "irq enabled");
    axi_wr(`TPW_ADDR_STATUS, 32'hFFFFFFFF, rs);
    chk_reg({30'h0, rs}, 32'h0, "status write");
    axi_wr(`TPW_ADDR_INT_CLEAR, 32'h2, rs);
    chk_reg({31'h0, irq}, 32'h0, "irq cleared");
    $display("test interrupt done");
    axi_wr(`TPW_ADDR_CTRL, 32'h0, rs);
    axi_rd(`TPW_ADDR_CTRL, rd, rs);
    chk_reg(rd, 32'h0, "ctrl stop");
    repeat (24) begin
      @(posedge clk_sys);
      if (sample_valid !== 1'b0) n_idle++;
    end
    chk_reg(n_idle, 32'h0, "sample while stopped");
    chk_flags(3'b100);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    chk_flags(3'b000);
    axi_rd(`TPW_ADDR_CTRL, rd, rs);
    chk_reg(rd, 32'h1, "ctrl after reset");
    apply(8'h19);
    chk_flags(3'b010);
    $display("test stop_reset done");
    give_verdict();
  end
endmodule // tb
`default_nettype wire
